// *** verilog/selftest_pm_pkg.sv ***
// shared constants and types for the self-test, soft reset and power-management registers
package selftest_pm_pkg;

	//////////////////////////////////////////////////////////////////////////////
	// register offsets on the host register port
	localparam logic [15:0] MEMORY_SELFTEST_INFO_OFS = 16'h0214;
	localparam logic [15:0] GLOBAL_SOFT_RESET_OFS = 16'h0216;
	localparam logic [15:0] POWER_MGMT_CAPABILITIES_OFS = 16'h0218;

	//////////////////////////////////////////////////////////////////////////////
	// self-test info field positions
	localparam int TX_SELFTEST_DONE_BIT = 12;
	localparam int TX_SELFTEST_FAIL_BIT = 11;
	localparam int RX_SELFTEST_DONE_BIT = 4;
	localparam int RX_SELFTEST_FAIL_BIT = 3;

	// global soft reset field and reset value
	localparam int SOFT_RESET_BIT = 0;
	localparam logic SOFT_RESET_RST = 1'b0;

	//////////////////////////////////////////////////////////////////////////////
	// capability field positions
	localparam int CAP_WAKE_D3COLD_BIT = 15;
	localparam int CAP_WAKE_D3HOT_BIT = 14;
	localparam int CAP_WAKE_FROM_D2_BIT = 13;
	localparam int CAP_WAKE_FROM_D1_BIT = 12;
	localparam int CAP_WAKE_D0_BIT = 11;
	localparam int CAP_D2_STATE_BIT = 10;
	localparam int CAP_D1_STATE_BIT = 9;
	localparam int CAP_AUX_CURRENT_LSB = 6;
	localparam int CAP_SPECIAL_INIT_BIT = 5;
	localparam int CAP_NEEDS_BUS_CLOCK_BIT = 3;
	localparam int CAP_PM_VERSION_LSB = 0;

	// bits taken from the configuration word; aux current stays 000
	localparam logic [15:0] CAP_LOADED_MASK = (16'h0001 << CAP_WAKE_FROM_D2_BIT)
		| (16'h0001 << CAP_WAKE_FROM_D1_BIT) | (16'h0001 << CAP_D2_STATE_BIT)
		| (16'h0001 << CAP_D1_STATE_BIT) | (16'h0001 << CAP_SPECIAL_INIT_BIT)
		| (16'h0001 << CAP_NEEDS_BUS_CLOCK_BIT) | (16'h0007 << CAP_PM_VERSION_LSB);
	// d3hot wake always reported, d3cold and d0 wake never
	localparam logic [15:0] CAP_FIXED_ONES = 16'h0001 << CAP_WAKE_D3HOT_BIT;
	localparam logic [15:0] CAP_RST = CAP_FIXED_ONES;

	// configuration-parameter word index in the serial memory
	localparam logic [5:0] EEPROM_CFG_WORD_INDEX = 6'h06;

	//////////////////////////////////////////////////////////////////////////////
	// power state codes as held in the control/status word
	localparam logic [1:0] PSTATE_D0 = 2'h0;
	localparam logic [1:0] PSTATE_D1 = 2'h1;
	localparam logic [1:0] PSTATE_D2 = 2'h2;
	localparam logic [1:0] PSTATE_D3HOT = 2'h3;

	// host register port request
	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic [1:0] be;
		logic [15:0] wdata;
	} reg_req_t;

endpackage

// *** verilog/buffer_selftest.sv ***
// march-style self-test engine for one packet buffer, run once after hardware reset
`timescale 1ns/100ps

module buffer_selftest #(
	parameter int ADDR_W = 10,
	parameter int DATA_W = 32
)
(
	input wire logic mclk,
	input wire logic rst_n,
	output logic [ADDR_W-1:0] mem_addr,
	output logic mem_we,
	output logic [DATA_W-1:0] mem_wdata,
	input wire logic [DATA_W-1:0] mem_rdata,
	output logic done,
	output logic fail
);
	import selftest_pm_pkg::*;

	typedef enum logic [1:0] {ST_WRITE, ST_READ, ST_CHECK, ST_DONE} bist_state_t;

	bist_state_t state_reg, state_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic pass_reg, pass_next;
	logic done_reg, done_next;
	logic fail_reg, fail_next;
	logic last_addr;

	// alternating stripes, inverted on the second pass to hit both cell values
	function automatic logic [DATA_W-1:0] stripe(input logic inv);
		logic [DATA_W-1:0] p;
		p = '0;
		for (int i = 0; i < DATA_W; i++)
		begin
			p[i] = (i % 2 == 1) ^ inv;
		end
		return p;
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// sweep: write all, then read back one word per two cycles (memory has one-cycle read)
	always_comb
	begin
		state_next = state_reg;
		addr_next = addr_reg;
		pass_next = pass_reg;
		done_next = done_reg;
		fail_next = fail_reg;
		last_addr = (addr_reg == {ADDR_W{1'b1}});
		unique case (state_reg)
			ST_WRITE:
			begin
				addr_next = addr_reg + 1'b1;
				if (last_addr)
				begin
					state_next = ST_READ;
				end
			end
			ST_READ:
			begin
				state_next = ST_CHECK;
			end
			ST_CHECK:
			begin
				if (mem_rdata != stripe(pass_reg))
				begin
					fail_next = 1'b1;
				end
				addr_next = addr_reg + 1'b1;
				state_next = ST_READ;
				if (last_addr)
				begin
					if (pass_reg)
					begin
						done_next = 1'b1;
						state_next = ST_DONE;
					end
					else
					begin
						pass_next = 1'b1;
						state_next = ST_WRITE;
					end
				end
			end
			ST_DONE:
			begin
				// flags frozen until the next hardware reset
				state_next = ST_DONE;
			end
		endcase
	end

	// starts by itself as soon as reset is released
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_WRITE;
			addr_reg <= '0;
			pass_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			pass_reg <= pass_next;
			done_reg <= done_next;
			fail_reg <= fail_next;
		end
	end

	// memory port; the buffer owner takes over once done is high
	assign mem_addr = addr_reg;
	assign mem_we = (state_reg == ST_WRITE);
	assign mem_wdata = stripe(pass_reg);
	assign done = done_reg;
	assign fail = fail_reg;

endmodule

// *** verilog/bist_reset_pm_caps_regs.sv ***
// self-test info, global soft reset and power-management capability registers
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
module bist_reset_pm_caps_regs #(
	parameter int TX_ADDR_W = 10,
	parameter int RX_ADDR_W = 10,
	parameter int MEM_DATA_W = 32
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire selftest_pm_pkg::reg_req_t reg_req,
	output logic reg_ack,
	output logic [15:0] reg_rdata,
	input wire logic eeprom_present_strap,
	input wire logic eeprom_word_valid,
	input wire logic [5:0] eeprom_word_index,
	input wire logic [15:0] eeprom_word_data,
	output logic soft_reset_active,
	input wire logic [1:0] power_state,
	input wire logic wake_event_enable,
	input wire logic wake_request,
	output logic wake_event_out_n,
	output logic wake_event_oe,
	output logic [15:0] capability_identifier_word_hi,
	output logic [TX_ADDR_W-1:0] tx_mem_addr,
	output logic tx_mem_we,
	output logic [MEM_DATA_W-1:0] tx_mem_wdata,
	input wire logic [MEM_DATA_W-1:0] tx_mem_rdata,
	output logic [RX_ADDR_W-1:0] rx_mem_addr,
	output logic rx_mem_we,
	output logic [MEM_DATA_W-1:0] rx_mem_wdata,
	input wire logic [MEM_DATA_W-1:0] rx_mem_rdata,
	output logic selftest_complete
);
	import selftest_pm_pkg::*;

	//////////////////////////////////////////////////////////////////////////////
	// declarations

	logic tx_done;
	logic tx_fail;
	logic rx_done;
	logic rx_fail;

	logic soft_reset_reg, soft_reset_next;
	logic ack_reg, ack_next;
	logic [15:0] rdata_reg, rdata_next;

	logic strap_s1_reg;
	logic strap_s2_reg;
	logic strap_s3_reg;
	logic strap_level_reg, strap_level_next;

	logic [15:0] caps_reg, caps_next;
	logic wake_reg, wake_next;
	logic wake_allowed;

	logic hit_info;
	logic hit_reset;
	logic hit_caps;

	// address compare shared by the read and write paths
	function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] ofs);
		return (addr == ofs);
	endfunction

	// keep only the loadable bits and force the fixed ones
	function automatic logic [15:0] caps_from_word(input logic [15:0] word);
		return (word & CAP_LOADED_MASK) | CAP_FIXED_ONES;
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// buffer self-test engines, one per buffer

	buffer_selftest #(
		.ADDR_W(TX_ADDR_W),
		.DATA_W(MEM_DATA_W)
	) tx_selftest (
		.mclk(mclk),
		.rst_n(rst_n),
		.mem_addr(tx_mem_addr),
		.mem_we(tx_mem_we),
		.mem_wdata(tx_mem_wdata),
		.mem_rdata(tx_mem_rdata),
		.done(tx_done),
		.fail(tx_fail)
	);

	buffer_selftest #(
		.ADDR_W(RX_ADDR_W),
		.DATA_W(MEM_DATA_W)
	) rx_selftest (
		.mclk(mclk),
		.rst_n(rst_n),
		.mem_addr(rx_mem_addr),
		.mem_we(rx_mem_we),
		.mem_wdata(rx_mem_wdata),
		.mem_rdata(rx_mem_rdata),
		.done(rx_done),
		.fail(rx_fail)
	);

	//////////////////////////////////////////////////////////////////////////////
	// strap synchroniser; first stage feeds only the second

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_s1_reg <= 1'b0;
			strap_s2_reg <= 1'b0;
			strap_s3_reg <= 1'b0;
		end
		else
		begin
			strap_s1_reg <= eeprom_present_strap;
			strap_s2_reg <= strap_s1_reg;
			strap_s3_reg <= strap_s2_reg;
		end
	end

	// a change is taken once stages two and three agree
	always_comb
	begin
		strap_level_next = strap_level_reg;
		if (strap_s2_reg == strap_s3_reg)
		begin
			strap_level_next = strap_s3_reg;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_level_reg <= 1'b0;
		end
		else
		begin
			strap_level_reg <= strap_level_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// address decode

	assign hit_info = addr_hit(reg_req.addr, MEMORY_SELFTEST_INFO_OFS);
	assign hit_reset = addr_hit(reg_req.addr, GLOBAL_SOFT_RESET_OFS);
	assign hit_caps = addr_hit(reg_req.addr, POWER_MGMT_CAPABILITIES_OFS);

	//////////////////////////////////////////////////////////////////////////////
	// soft reset control; only software clears it, the bit is not self-clearing

	always_comb
	begin
		soft_reset_next = soft_reset_reg;
		if (reg_req.wr && hit_reset && reg_req.be[0])
		begin
			soft_reset_next = reg_req.wdata[SOFT_RESET_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			soft_reset_reg <= SOFT_RESET_RST;
		end
		else
		begin
			soft_reset_reg <= soft_reset_next;
		end
	end

	// the rest of the device holds its registers in reset while this is high
	assign soft_reset_active = soft_reset_reg;

	//////////////////////////////////////////////////////////////////////////////
	// capability word; writes are ignored, it is part of config space and
	// therefore survives a soft reset

	always_comb
	begin
		caps_next = caps_reg;
		if (!strap_level_reg)
		begin
			// no serial memory: every loaded bit reads zero
			caps_next = CAP_RST;
		end
		else if (eeprom_word_valid && (eeprom_word_index == EEPROM_CFG_WORD_INDEX))
		begin
			caps_next = caps_from_word(eeprom_word_data);
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			caps_reg <= CAP_RST;
		end
		else
		begin
			caps_reg <= caps_next;
		end
	end

	// mirror into the upper half of the capability identifier config word
	assign capability_identifier_word_hi = caps_reg;

	//////////////////////////////////////////////////////////////////////////////
	// wake event output, open-drain: pulls low only in states the word allows

	always_comb
	begin
		wake_allowed = 1'b0;
		unique case (power_state)
			PSTATE_D0: wake_allowed = caps_reg[CAP_WAKE_D0_BIT];
			PSTATE_D1: wake_allowed = caps_reg[CAP_WAKE_FROM_D1_BIT];
			PSTATE_D2: wake_allowed = caps_reg[CAP_WAKE_FROM_D2_BIT];
			PSTATE_D3HOT: wake_allowed = caps_reg[CAP_WAKE_D3HOT_BIT];
		endcase
		wake_next = wake_request && wake_event_enable && wake_allowed;
		if (soft_reset_reg)
		begin
			wake_next = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wake_reg <= 1'b0;
		end
		else
		begin
			wake_reg <= wake_next;
		end
	end

	// the pin is released, never driven high
	assign wake_event_out_n = 1'b0;
	assign wake_event_oe = wake_reg;

	//////////////////////////////////////////////////////////////////////////////
	// register read path; answer one cycle after the strobe, unmapped reads zero.
	// reads still answer during soft reset so software can see and clear the bit

	always_comb
	begin
		ack_next = reg_req.rd || reg_req.wr;
		rdata_next = rdata_reg;
		if (reg_req.rd)
		begin
			rdata_next = 16'h0000;
			if (hit_info)
			begin
				rdata_next[TX_SELFTEST_DONE_BIT] = tx_done;
				rdata_next[TX_SELFTEST_FAIL_BIT] = tx_fail;
				rdata_next[RX_SELFTEST_DONE_BIT] = rx_done;
				rdata_next[RX_SELFTEST_FAIL_BIT] = rx_fail;
			end
			else if (hit_reset)
			begin
				rdata_next[SOFT_RESET_BIT] = soft_reset_reg;
			end
			else if (hit_caps)
			begin
				rdata_next = caps_reg;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_reg <= 1'b0;
			rdata_reg <= 16'h0000;
		end
		else
		begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_ack = ack_reg;
	assign reg_rdata = rdata_reg;
	// both buffers finished; the buffers may be handed to the data path
	assign selftest_complete = tx_done && rx_done;

endmodule

// *** test/bist_reset_pm_caps_regs_checker.sv ***
// port assertions for the self-test, soft reset and capability registers
`timescale 1ns/100ps

module bist_reset_pm_caps_regs_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire selftest_pm_pkg::reg_req_t reg_req,
	input wire logic reg_ack,
	input wire logic [15:0] reg_rdata,
	input wire logic eeprom_present_strap,
	input wire logic eeprom_word_valid,
	input wire logic [5:0] eeprom_word_index,
	input wire logic [15:0] eeprom_word_data,
	input wire logic soft_reset_active,
	input wire logic [1:0] power_state,
	input wire logic wake_event_enable,
	input wire logic wake_request,
	input wire logic wake_event_oe,
	input wire logic [15:0] capability_identifier_word_hi,
	input wire logic selftest_complete
);
	import selftest_pm_pkg::*;
	logic [15:0] cap;
	logic sr_wr;
	logic req;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	//////////////////////////////////////////////////////////////////////////////
	// short aliases keep the properties readable
	assign cap = capability_identifier_word_hi;
	assign sr_wr = reg_req.wr && reg_req.addr == GLOBAL_SOFT_RESET_OFS && reg_req.be[0];
	assign req = reg_req.rd || reg_req.wr;

	// isolated requests only, so a late or stuck ack shows
	a_ack_one_cycle: assert property ((req ##1 !req) |-> reg_ack ##1 !reg_ack)
		else $error("ack not a single cycle after request");
	a_mirror_read: assert property (
		reg_req.rd && reg_req.addr == POWER_MGMT_CAPABILITIES_OFS |=> reg_rdata == $past(cap))
		else $error("capability read differs from mirror");
	a_caps_fixed: assert property (
		cap[15:14] == 2'h1 && !cap[11] && cap[8:6] == 3'h0 && !cap[4])
		else $error("fixed capability bits wrong");
	a_caps_load: assert property (
		eeprom_present_strap [*6] ##0 (eeprom_word_valid && eeprom_word_index == 6'h06)
		|=> cap == (($past(eeprom_word_data) & 16'h362F) | 16'h4000))
		else $error("capability word not loaded");
	a_caps_no_strap: assert property (
		!eeprom_present_strap [*6] |=> cap == 16'h4000)
		else $error("capability not default without memory");
	a_wake_blocked: assert property (
		soft_reset_active || !wake_request || !wake_event_enable || power_state == PSTATE_D0
		|=> !wake_event_oe)
		else $error("wake asserted when not allowed");
	a_wake_low_states: assert property (
		(power_state == PSTATE_D1 && !cap[12]) || (power_state == PSTATE_D2 && !cap[13])
		|=> !wake_event_oe)
		else $error("wake in d1 or d2 without capability");
	a_wake_d3hot: assert property (
		wake_request && wake_event_enable && !soft_reset_active && power_state == PSTATE_D3HOT
		|=> wake_event_oe)
		else $error("wake missing in d3hot");
	a_soft_reset_write: assert property (
		sr_wr |=> soft_reset_active == $past(reg_req.wdata[0]))
		else $error("soft reset bit not written");
	a_soft_reset_hold: assert property (!sr_wr |=> $stable(soft_reset_active))
		else $error("soft reset bit changed by itself");
	a_selftest_hold: assert property (selftest_complete |=> selftest_complete)
		else $error("self-test completion dropped");

	// main scenarios reached
	c_caps_read: cover property (reg_req.rd && reg_req.addr == POWER_MGMT_CAPABILITIES_OFS);
	c_wake: cover property (wake_event_oe);
	c_selftest: cover property ($rose(selftest_complete));
	c_soft_reset: cover property (soft_reset_active);
endmodule

bind bist_reset_pm_caps_regs bist_reset_pm_caps_regs_checker chk (.mclk, .rst_n, .reg_req,
	.reg_ack, .reg_rdata, .eeprom_present_strap, .eeprom_word_valid, .eeprom_word_index,
	.eeprom_word_data, .soft_reset_active, .power_state, .wake_event_enable, .wake_request,
	.wake_event_oe, .capability_identifier_word_hi, .selftest_complete);

// *** test/bist_reset_pm_caps_regs_bench.sv ***
// register-level bench for the self-test, soft reset and capability registers
`timescale 1ns/100ps

module bist_reset_pm_caps_regs_bench;
	import selftest_pm_pkg::*;
	logic mclk, rst_n, strap, ev_v, wk_en, wk_req, reg_ack, sr_act, oe, out_n, done;
	logic tx_we, rx_we;
	logic [1:0] pst;
	logic [2:0] tx_a, rx_a;
	logic [5:0] ev_i;
	logic [15:0] ev_d, rdata, cap, q;
	logic [31:0] tx_wd, rx_wd, tx_rd, rx_rd;
	logic [31:0] txm [8];
	logic [31:0] rxm [8];
	logic [15:0] wd [4] = '{16'hFFFF, 16'h0000, 16'hA5A5, 16'h2000};
	reg_req_t req;
	int error_cnt = 0;
	int compares = 0;

	bist_reset_pm_caps_regs #(.TX_ADDR_W(3), .RX_ADDR_W(3), .MEM_DATA_W(32)) dut (
		.mclk(mclk), .rst_n(rst_n), .reg_req(req), .reg_ack(reg_ack), .reg_rdata(rdata),
		.eeprom_present_strap(strap), .eeprom_word_valid(ev_v), .eeprom_word_index(ev_i),
		.eeprom_word_data(ev_d), .soft_reset_active(sr_act), .power_state(pst),
		.wake_event_enable(wk_en), .wake_request(wk_req), .wake_event_out_n(out_n),
		.wake_event_oe(oe), .capability_identifier_word_hi(cap), .tx_mem_addr(tx_a),
		.tx_mem_we(tx_we), .tx_mem_wdata(tx_wd), .tx_mem_rdata(tx_rd), .rx_mem_addr(rx_a),
		.rx_mem_we(rx_we), .rx_mem_wdata(rx_wd), .rx_mem_rdata(rx_rd),
		.selftest_complete(done));

	//////////////////////////////////////////////////////////////////////////////
	// 20 MHz clock
	initial
	begin
		mclk = 0;
		forever #25 mclk = ~mclk;
	end

	// buffer models; rx bit 0 stuck high so only the rx test can fail
	always @(negedge mclk)
	begin
		if (tx_we) txm[tx_a] <= tx_wd;
		if (rx_we) rxm[rx_a] <= rx_wd;
		tx_rd <= txm[tx_a];
		rx_rd <= rxm[rx_a] | 32'h1;
	end

	//////////////////////////////////////////////////////////////////////////////
	task complete_run;
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask

	// one-cycle strobe; ack and read data are due in the following cycle
	task acc(input logic r, input logic [15:0] a, input logic [15:0] d, input logic [1:0] b);
		@(negedge mclk);
		req = '{a, r, !r, b, d};
		@(negedge mclk);
		req = '0;
		chk("ack", {15'h0, reg_ack}, 16'h0001);
		q = rdata;
	endtask

	task rd(input string n, input logic [15:0] a, input logic [15:0] exp);
		acc(1'b1, a, 16'h0000, 2'h3);
		chk(n, q, exp);
	endtask

	task ld(input logic [5:0] i, input logic [15:0] d);
		@(negedge mclk);
		ev_v = 1;
		ev_i = i;
		ev_d = d;
		@(negedge mclk);
		ev_v = 0;
	endtask

	task wk(input logic [1:0] s, input logic e, input logic x);
		@(negedge mclk);
		pst = s;
		wk_en = e;
		wk_req = 1;
		@(negedge mclk);
		chk("wake_oe", {15'h0, oe}, {15'h0, x});
	endtask

	//////////////////////////////////////////////////////////////////////////////
	// watchdog well beyond the roughly 130 cycles the sequence needs
	initial
	begin
		repeat (3000) @(posedge mclk);
		error_cnt++;
		complete_run;
	end

	// main sequence
	initial
	begin
		rst_n = 0;
		req = '0;
		strap = 0;
		ev_v = 0;
		ev_i = '0;
		ev_d = '0;
		pst = PSTATE_D0;
		wk_en = 0;
		wk_req = 0;
		repeat (8) @(negedge mclk);
		chk("caps_rst", cap, 16'h4000);
		chk("complete_rst", {15'h0, done}, 16'h0000);
		chk("soft_rst", {15'h0, sr_act}, 16'h0000);
		rst_n = 1;
		for (int i = 0; i < 200 && done !== 1'b1; i++) @(negedge mclk);
		chk("complete", {15'h0, done}, 16'h0001);
		rd("selftest", MEMORY_SELFTEST_INFO_OFS, 16'h1018);
		rd("soft", GLOBAL_SOFT_RESET_OFS, 16'h0000);
		acc(1'b0, POWER_MGMT_CAPABILITIES_OFS, 16'hFFFF, 2'h3);
		rd("caps", POWER_MGMT_CAPABILITIES_OFS, 16'h4000);
		rd("unmapped", 16'h021A, 16'h0000);
		ld(6'h06, 16'hFFFF);
		chk("caps_nostrap", cap, 16'h4000);
		strap = 1;
		repeat (6) @(negedge mclk);
		// each word checks the loaded and the fixed bits together
		foreach (wd[i])
		begin
			ld(6'h06, wd[i]);
			chk("mirror", cap, (wd[i] & 16'h362F) | 16'h4000);
		end
		ld(6'h05, 16'hFFFF);
		chk("caps_idx", cap, 16'h6000);
		rd("caps", POWER_MGMT_CAPABILITIES_OFS, 16'h6000);
		wk(PSTATE_D0, 1'b1, 1'b0);
		wk(PSTATE_D1, 1'b1, 1'b0);
		wk(PSTATE_D2, 1'b1, 1'b1);
		wk(PSTATE_D3HOT, 1'b1, 1'b1);
		wk(PSTATE_D2, 1'b0, 1'b0);
		chk("wake_pin", {15'h0, out_n}, 16'h0000);
		ld(6'h06, 16'h1000);
		wk(PSTATE_D1, 1'b1, 1'b1);
		wk(PSTATE_D2, 1'b1, 1'b0);
		wk(PSTATE_D3HOT, 1'b1, 1'b1);
		acc(1'b0, GLOBAL_SOFT_RESET_OFS, 16'h0001, 2'h1);
		chk("soft_on", {15'h0, sr_act}, 16'h0001);
		rd("soft", GLOBAL_SOFT_RESET_OFS, 16'h0001);
		wk(PSTATE_D3HOT, 1'b1, 1'b0);
		rd("caps_kept", POWER_MGMT_CAPABILITIES_OFS, 16'h5000);
		rd("selftest_kept", MEMORY_SELFTEST_INFO_OFS, 16'h1018);
		acc(1'b0, GLOBAL_SOFT_RESET_OFS, 16'h0000, 2'h2);
		rd("soft_held", GLOBAL_SOFT_RESET_OFS, 16'h0001);
		acc(1'b0, GLOBAL_SOFT_RESET_OFS, 16'h0000, 2'h1);
		chk("soft_off", {15'h0, sr_act}, 16'h0000);
		wk(PSTATE_D3HOT, 1'b1, 1'b1);
		chk("complete_kept", {15'h0, done}, 16'h0001);
		strap = 0;
		repeat (6) @(negedge mclk);
		chk("caps_unfit", cap, 16'h4000);
		wk(PSTATE_D1, 1'b1, 1'b0);
		complete_run;
	end
endmodule
